/* File: src/csc_pkg.sv */
package csc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int SETTLE_MS = 30;
  localparam int TERM_MS = 30;
  localparam int WD_PERIOD_MS = 80000;
  localparam int PREQUAL_MIN = 30;
  localparam int PREQUAL_MS = PREQUAL_MIN * 60000;
  localparam logic [25:0] FC_LIMIT_MS [0:3] = '{26'd10800000, 26'd14400000,
                                                26'd18000000, 26'd21600000};
  localparam logic [25:0] TO_LIMIT_MS [0:3] = '{26'd600000, 26'd1200000,
                                                26'd1800000, 26'd3600000};

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] OFS_CFG0 = 32'h0000_0000;
  localparam logic [31:0] OFS_CFG1 = 32'h0000_0004;
  localparam logic [31:0] OFS_CFG2 = 32'h0000_0008;
  localparam logic [31:0] OFS_WDCLR = 32'h0000_000c;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0010;
  localparam logic [3:0] MODE_DEFAULT = 4'h5;
  localparam logic [3:0] MODE_CHG_ON = 4'h5;
  localparam int CFG1_WDEN_BIT = 0;
  localparam int CFG1_PROF_BIT = 1;
  localparam int CFG1_FC_LSB = 2;
  localparam int CFG1_TO_LSB = 4;
  localparam logic [5:0] CFG1_RESET = 6'h02;
  localparam int CFG2_COOLPCT_LSB = 8;
  localparam int CFG2_CVT_LSB = 16;
  localparam int CFG2_COOLCV_LSB = 24;
  localparam logic [31:0] CFG2_RESET = 32'h0000_3264;
  localparam logic [7:0] WDCLR_KEY = 8'h01;
  localparam int ST_OK_BIT = 4;
  localparam int ST_FB_BIT = 5;
  localparam int ST_THM_LSB = 8;
  localparam int ST_STATE_LSB = 12;

  // ----------------------------------------------------------------
  // Detail codes, bands, analog targets
  // ----------------------------------------------------------------
  localparam logic [3:0] DTL_PREQUAL = 4'h0;
  localparam logic [3:0] DTL_CC = 4'h1;
  localparam logic [3:0] DTL_CV = 4'h2;
  localparam logic [3:0] DTL_TOPOFF = 4'h3;
  localparam logic [3:0] DTL_DONE = 4'h4;
  localparam logic [3:0] DTL_TFAULT = 4'h6;
  localparam logic [3:0] DTL_IDLE = 4'h8;
  localparam logic [3:0] DTL_DIE_SHUTDOWN_TEMPERATURE = 4'ha;
  localparam logic [3:0] DTL_WDOG = 4'hb;
  localparam logic [2:0] BAND_COLD = 3'h0;
  localparam logic [2:0] BAND_COOL = 3'h1;
  localparam logic [2:0] BAND_NORMAL = 3'h2;
  localparam logic [2:0] BAND_WARM = 3'h3;
  localparam logic [2:0] BAND_HOT = 3'h4;
  localparam logic [10:0] FB_PCT_PER_DEG = 11'h005;
  localparam logic [7:0] WARM_DROP_MV = 8'hb4;
  localparam logic [6:0] FULL_PCT = 7'h64;
  localparam logic [6:0] HALF_PCT = 7'h32;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_PQ = 4'h1, S_CC = 4'h3, S_CV = 4'h2, S_TOPOFF = 4'h6,
    S_DONE = 4'h7, S_TFAULT = 4'h5, S_WDSUSP = 4'h4, S_DIE_SHUTDOWN_TEMPERATURE = 4'hc
  } csc_state_t;

endpackage

/* File: src/csc_top.sv */
`timescale 1ns/1ps
module csc_top
  import csc_pkg::*;
#(
  parameter int TICK_CYCLES_P = csc_pkg::TICK_CYCLES,
  parameter int SETTLE_TICKS = csc_pkg::SETTLE_MS,
  parameter int TERM_TICKS = csc_pkg::TERM_MS,
  parameter int WD_TICKS = csc_pkg::WD_PERIOD_MS,
  parameter int PQ_TICKS = csc_pkg::PREQUAL_MS
) (
  input  wire logic        MCLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        CHGIN_VALID_I,
  input  wire logic        PREQUAL_I,
  input  wire logic        VBAT_AT_REG_I,
  input  wire logic        VBAT_BELOW_RESTART_I,
  input  wire logic        ICHG_BELOW_TOPOFF_I,
  input  wire logic        TJ_SHDN_I,
  input  wire logic [7:0]  DIE_TEMP_I,
  input  wire logic [2:0]  BATT_TEMP_BAND_I,
  input  wire logic        BAT_DISCONNECT_I,
  output logic             CHARGE_EN_O,
  output logic      [6:0]  CUR_PCT_O,
  output logic      [7:0]  CV_TARGET_O,
  output logic      [7:0]  CV_DROP_MV_O,
  output logic             SOFTSTART_EN_O,
  output logic             CHG_IRQ_O,
  output logic             CHARGER_OK_FLAG_O,
  output logic      [3:0]  CHG_DETAIL_O,
  output logic             FOLDBACK_O
);
  import csc_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) rst_sync <= 2'b00;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [15:0] tick_cnt;
  logic        tick;

  assign tick = (tick_cnt == 16'(TICK_CYCLES_P - 1));
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) tick_cnt <= '0;
    else if (tick) tick_cnt <= '0;
    else tick_cnt <= tick_cnt + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  csc_state_t  state;
  csc_state_t  next_state;
  logic [3:0]  mode;
  logic [5:0]  cfg1;
  logic [31:0] cfg2;
  logic        ok;
  logic [3:0]  detail;
  logic        irq;
  logic        fb_status;
  logic [25:0] state_timer;
  logic [25:0] fc_timer;
  logic [15:0] term_timer;
  logic [25:0] wd_cnt;
  logic        wd_expired;
  logic        wd_clear;
  logic        disq_seen;
  logic        ss_skip;
  logic        chg_on;
  logic        transition;
  logic        settle_hit;
  logic        wd_en;
  logic        prof_en;
  logic [2:0]  band;
  logic        temp_suspend;
  logic        timer_double;
  logic [25:0] fc_limit;
  logic [25:0] to_limit;
  logic        charging;
  logic [6:0]  cool_pct;
  logic        wr_pend;
  logic [31:0] wr_addr;

  assign wd_en = cfg1[CFG1_WDEN_BIT];
  assign prof_en = cfg1[CFG1_PROF_BIT];
  assign cool_pct = cfg2[CFG2_COOLPCT_LSB +: 7];
  assign chg_on = (mode == MODE_CHG_ON);
  assign transition = (next_state != state);
  assign settle_hit = tick && !transition && (state_timer == 26'(SETTLE_TICKS - 1));
  assign band = prof_en ? BATT_TEMP_BAND_I : BAND_NORMAL;
  assign temp_suspend = (band == BAND_COLD) || (band == BAND_HOT);
  assign timer_double = (band == BAND_COOL) && (cool_pct <= HALF_PCT);
  assign fc_limit = timer_double ? {FC_LIMIT_MS[cfg1[CFG1_FC_LSB +: 2]][24:0], 1'b0}
                                 : FC_LIMIT_MS[cfg1[CFG1_FC_LSB +: 2]];
  assign to_limit = TO_LIMIT_MS[cfg1[CFG1_TO_LSB +: 2]];
  assign charging = (state == S_PQ) || (state == S_CC) || (state == S_CV) ||
                    (state == S_TOPOFF);
  assign wd_expired = wd_en && (wd_cnt >= 26'(WD_TICKS));

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Zero wait states: read data is fetched in the address phase.
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      HRDATA_O <= '0;
    end else begin
      wr_pend <= HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I;
      if (HSEL_I && HTRANS_I[1] && HREADY_I) begin
        wr_addr <= HADDR_I;
        unique case (HADDR_I)
          OFS_CFG0: HRDATA_O <= {28'h0, mode};
          OFS_CFG1: HRDATA_O <= {26'h0, cfg1};
          OFS_CFG2: HRDATA_O <= cfg2;
          OFS_STATUS: HRDATA_O <= {16'h0, state, 1'b0, band, 2'b00, fb_status, ok, detail};
          default: HRDATA_O <= '0;
        endcase
      end
    end
  end

  assign wd_clear = wr_pend && (wr_addr == OFS_WDCLR) && (HWDATA_I[7:0] == WDCLR_KEY);

  // Configuration; shutdown overrides any write in the same cycle
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      mode <= MODE_DEFAULT;
      cfg1 <= CFG1_RESET;
      cfg2 <= CFG2_RESET;
    end else if (next_state == S_DIE_SHUTDOWN_TEMPERATURE) begin
      mode <= MODE_DEFAULT;
      cfg1 <= CFG1_RESET;
      cfg2 <= CFG2_RESET;
    end else if (wr_pend) begin
      if (wr_addr == OFS_CFG0) mode <= HWDATA_I[3:0];
      if (wr_addr == OFS_CFG1) cfg1 <= HWDATA_I[5:0];
      if (wr_addr == OFS_CFG2) cfg2 <= HWDATA_I;
    end
  end

  // ----------------------------------------------------------------
  // Charge state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (state != S_DIE_SHUTDOWN_TEMPERATURE && TJ_SHDN_I) begin
      next_state = S_DIE_SHUTDOWN_TEMPERATURE;
    end else if (state == S_DIE_SHUTDOWN_TEMPERATURE) begin
      if (!TJ_SHDN_I) next_state = S_IDLE;
    end else if (!chg_on || !CHGIN_VALID_I) begin
      next_state = S_IDLE;
    end else begin
      unique case (state)
        S_IDLE: next_state = PREQUAL_I ? S_PQ : S_CC;
        S_PQ: begin
          if (wd_expired) next_state = S_WDSUSP;
          else if (state_timer >= 26'(PQ_TICKS)) next_state = S_TFAULT;
          else if (!PREQUAL_I) next_state = S_CC;
        end
        S_CC: begin
          if (wd_expired) next_state = S_WDSUSP;
          else if (fc_timer >= fc_limit) next_state = S_TFAULT;
          else if (VBAT_AT_REG_I) next_state = S_CV;
        end
        S_CV: begin
          if (wd_expired) next_state = S_WDSUSP;
          else if (fc_timer >= fc_limit) next_state = S_TFAULT;
          else if (term_timer >= 16'(TERM_TICKS)) next_state = S_TOPOFF;
        end
        S_TOPOFF: begin
          if (wd_expired) next_state = S_WDSUSP;
          else if (VBAT_BELOW_RESTART_I) next_state = S_CC;
          else if (state_timer >= to_limit) next_state = S_DONE;
        end
        S_DONE: begin
          if (wd_expired) next_state = S_WDSUSP;
          else if (VBAT_BELOW_RESTART_I) next_state = S_CC;
        end
        S_TFAULT: if (disq_seen && !BAT_DISCONNECT_I) next_state = S_IDLE;
        S_WDSUSP: if (wd_clear) next_state = S_IDLE;
        default: next_state = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) state <= S_IDLE;
    else state <= next_state;
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) state_timer <= '0;
    else if (transition) state_timer <= '0;
    else if (tick && state_timer != '1) state_timer <= state_timer + 26'h1;
  end

  // CC and CV share one fast-charge budget
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) fc_timer <= '0;
    else if (!(next_state == S_CC || next_state == S_CV)) fc_timer <= '0;
    else if (state == S_TOPOFF || state == S_DONE) fc_timer <= '0;
    else if (tick && fc_timer != '1) fc_timer <= fc_timer + 26'h1;
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) term_timer <= '0;
    else if (state != S_CV || !ICHG_BELOW_TOPOFF_I) term_timer <= '0;
    else if (tick && term_timer != '1) term_timer <= term_timer + 16'h1;
  end

  // Counter is held at zero while idle or disabled, so no stale expiry
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) wd_cnt <= '0;
    else if (!wd_en || wd_clear || state == S_IDLE) wd_cnt <= '0;
    else if (tick && !wd_expired) wd_cnt <= wd_cnt + 26'h1;
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) disq_seen <= 1'b0;
    else if (state != S_TFAULT) disq_seen <= 1'b0;
    else if (BAT_DISCONNECT_I) disq_seen <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Detail code, ok flag, interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ok <= 1'b0;
      detail <= DTL_IDLE;
      irq <= 1'b0;
    end else begin
      irq <= (fb_status != (DIE_TEMP_I > cfg2[7:0]));
      if (transition && next_state == S_TFAULT) begin
        irq <= 1'b1;
        ok <= 1'b0;
        detail <= DTL_TFAULT;
      end else if (transition && next_state == S_DIE_SHUTDOWN_TEMPERATURE) begin
        if (ok) irq <= 1'b1;
        ok <= 1'b0;
        detail <= DTL_DIE_SHUTDOWN_TEMPERATURE;
      end else if (transition && next_state == S_WDSUSP) begin
        if (ok) irq <= 1'b1;
        ok <= 1'b0;
        detail <= DTL_WDOG;
      end else if (settle_hit) begin
        // Ok follows the detail code only, never foldback
        unique case (state)
          S_IDLE: detail <= DTL_IDLE;
          S_PQ: detail <= DTL_PREQUAL;
          S_CC: detail <= DTL_CC;
          S_CV: detail <= DTL_CV;
          S_TOPOFF: detail <= DTL_TOPOFF;
          S_DONE: detail <= DTL_DONE;
          default: detail <= detail;
        endcase
        if (state != S_TFAULT && state != S_DIE_SHUTDOWN_TEMPERATURE && state != S_WDSUSP) begin
          if (!ok) irq <= 1'b1;
          ok <= (state != S_DONE);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Foldback and analog targets
  // ----------------------------------------------------------------
  logic [10:0] fb_cut;
  logic [6:0]  base_pct;

  assign fb_cut = (DIE_TEMP_I > cfg2[7:0]) ? 11'(DIE_TEMP_I - cfg2[7:0]) * FB_PCT_PER_DEG
                                           : 11'h0;
  assign base_pct = (band == BAND_COOL) ? cool_pct : FULL_PCT;

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      fb_status <= 1'b0;
      CHARGE_EN_O <= 1'b0;
      CUR_PCT_O <= '0;
      CV_TARGET_O <= '0;
      CV_DROP_MV_O <= '0;
    end else begin
      fb_status <= (DIE_TEMP_I > cfg2[7:0]);
      CHARGE_EN_O <= charging && !temp_suspend;
      if (!charging || temp_suspend) CUR_PCT_O <= '0;
      else if (fb_cut >= {4'h0, base_pct}) CUR_PCT_O <= '0;
      else CUR_PCT_O <= base_pct - fb_cut[6:0];
      CV_TARGET_O <= (band == BAND_COOL) ? cfg2[CFG2_COOLCV_LSB +: 8]
                                         : cfg2[CFG2_CVT_LSB +: 8];
      CV_DROP_MV_O <= (band == BAND_WARM) ? WARM_DROP_MV : 8'h00;
    end
  end

  // Restart from done skips the soft-start ramp until CC is left
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) ss_skip <= 1'b0;
    else if (state == S_DONE && next_state == S_CC) ss_skip <= 1'b1;
    else if (state != S_CC) ss_skip <= 1'b0;
  end

  assign SOFTSTART_EN_O = !ss_skip && charging;
  assign CHG_IRQ_O = irq;
  assign CHARGER_OK_FLAG_O = ok;
  assign CHG_DETAIL_O = detail;
  assign FOLDBACK_O = fb_status;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!rst_n);

  AST_TFAULT_ENTRY: assert property (state == S_TFAULT && $past(state) != S_TFAULT
    |-> CHG_IRQ_O && !CHARGER_OK_FLAG_O && CHG_DETAIL_O == DTL_TFAULT ##1 !CHARGE_EN_O)
    else $error("timer fault entry wrong");
  AST_DIE_SHUTDOWN_TEMPERATURE_ENTRY: assert property (state == S_DIE_SHUTDOWN_TEMPERATURE && $past(state) != S_DIE_SHUTDOWN_TEMPERATURE
    |-> CHG_IRQ_O == $past(ok) && !CHARGER_OK_FLAG_O && CHG_DETAIL_O == DTL_DIE_SHUTDOWN_TEMPERATURE)
    else $error("shutdown entry wrong");
  AST_DIE_SHUTDOWN_TEMPERATURE_MODE: assert property (state == S_DIE_SHUTDOWN_TEMPERATURE |-> mode == MODE_DEFAULT && !wd_en)
    else $error("mode not restored in shutdown");
  AST_WD_ENTRY: assert property (state == S_WDSUSP && $past(state) != S_WDSUSP
    |-> CHG_IRQ_O == $past(ok) && !CHARGER_OK_FLAG_O && CHG_DETAIL_O == DTL_WDOG)
    else $error("watchdog entry wrong");
  AST_WD_GOES: assert property (wd_expired && chg_on && CHGIN_VALID_I && !TJ_SHDN_I
    && (state == S_CV || state == S_TOPOFF || state == S_DONE) |=> state == S_WDSUSP)
    else $error("watchdog expiry ignored");
  // Counter clears one edge after the enable drops
  AST_WD_IDLE: assert property (!wd_en |-> !wd_expired ##1 wd_cnt == '0)
    else $error("watchdog counts while disabled");
  AST_TOPOFF_SRC: assert property (state == S_TOPOFF && $past(state) != S_TOPOFF
    |-> $past(state) == S_CV) else $error("top-off entered from wrong state");
  AST_CV_SETTLE: assert property (state == S_CV && settle_hit
    |=> CHG_DETAIL_O == DTL_CV && CHARGER_OK_FLAG_O) else $error("CV settle update wrong");
  AST_DONE_SETTLE: assert property (state == S_DONE && settle_hit
    |=> CHG_DETAIL_O == DTL_DONE && !CHARGER_OK_FLAG_O && CHG_IRQ_O == !$past(ok))
    else $error("done settle update wrong");
  AST_DONE_ZERO: assert property (state == S_DONE && $past(state) == S_DONE
    |-> CUR_PCT_O == 7'h00 && !CHARGE_EN_O) else $error("current flows in done");
  AST_FB_IRQ: assert property ($changed(fb_status) |-> CHG_IRQ_O)
    else $error("foldback change without interrupt");
  AST_TEMP_SUSP: assert property (temp_suspend |=> !CHARGE_EN_O && CUR_PCT_O == 7'h00)
    else $error("charging in cold or hot band");

  COV_DONE: cover property (state == S_TOPOFF ##1 state == S_DONE);
  COV_TFAULT: cover property (state == S_CV ##1 state == S_TFAULT);
  COV_WDSUSP: cover property (state == S_WDSUSP ##1 state == S_IDLE);
  COV_FOLDBACK: cover property ($rose(fb_status));

endmodule

/* File: tb/csc_batt_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Battery pack: cell voltage climbs while charge is enabled
// ----------------------------------------------------------------
module csc_batt_model #(
  parameter int VPQ   = 10,
  parameter int VREG  = 40,
  parameter int VRST  = 38,
  parameter int VFULL = 100
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic charge_en_i,
  input  wire logic drain_i,
  output logic      prequal_o,
  output logic      at_reg_o,
  output logic      below_restart_o,
  output logic      ichg_low_o
);
  logic [6:0] vbat;

  // Drain holds the cell just under the restart level
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vbat <= 7'h00;
    end else if (drain_i) begin
      vbat <= 7'h23;
    end else if (charge_en_i && vbat != 7'h7f) begin
      vbat <= vbat + 7'h01;
    end
  end

  // Taper current modelled as time spent at regulation
  assign prequal_o       = vbat < VPQ;
  assign at_reg_o        = vbat >= VREG;
  assign below_restart_o = vbat < VRST;
  assign ichg_low_o      = vbat >= VFULL;
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import csc_pkg::*;
  logic        clk, rstn, hsel, hwrite, tj, drain, hready;
  logic        prequal, at_reg, below_rst, ichg_low, chg_en, irq, ok, fb;
  logic        vin, dis, hresp, softstart;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  die_temp, cv_tgt, cv_drop;
  logic [2:0]  band;
  logic [6:0]  cur_pct;
  logic [3:0]  detail;
  int          error_cnt, total_checks, irq_cnt, base;
  logic [2:0]  bt [5] = '{BAND_COLD, BAND_COOL, BAND_WARM, BAND_HOT, BAND_NORMAL};
  logic        ben [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  logic [7:0]  bpc [5] = '{8'h00, 8'h32, 8'h64, 8'h00, 8'h64};
  logic [7:0]  bcv [5] = '{8'h00, 8'h40, 8'h3c, 8'h00, 8'h3c};
  logic [7:0]  bdr [5] = '{8'h00, 8'h00, 8'hb4, 8'h00, 8'h00};

  csc_top #(.TICK_CYCLES_P(4), .SETTLE_TICKS(3), .TERM_TICKS(3), .WD_TICKS(20),
    .PQ_TICKS(30)) i_dut (
    .MCLK_I(clk), .RSTN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .CHGIN_VALID_I(vin),
    .PREQUAL_I(prequal), .VBAT_AT_REG_I(at_reg), .VBAT_BELOW_RESTART_I(below_rst),
    .ICHG_BELOW_TOPOFF_I(ichg_low), .TJ_SHDN_I(tj), .DIE_TEMP_I(die_temp),
    .BATT_TEMP_BAND_I(band), .BAT_DISCONNECT_I(dis), .CHARGE_EN_O(chg_en),
    .CUR_PCT_O(cur_pct), .CV_TARGET_O(cv_tgt), .CV_DROP_MV_O(cv_drop),
    .SOFTSTART_EN_O(softstart), .CHG_IRQ_O(irq), .CHARGER_OK_FLAG_O(ok), .CHG_DETAIL_O(detail),
    .FOLDBACK_O(fb));

  csc_batt_model i_batt (.clk_i(clk), .rstn_i(rstn), .charge_en_i(chg_en),
    .drain_i(drain), .prequal_o(prequal), .at_reg_o(at_reg),
    .below_restart_o(below_rst), .ichg_low_o(ichg_low));

  // ----------------------------------------------------------------
  // Bus master and checking helpers
  // ----------------------------------------------------------------
  task automatic results;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) begin
      chk(32'h0, 32'h1);
      results();
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask

  // Long waits end on the detail code, or fail after 3000 cycles without it
  task automatic wait_det(input logic [3:0] d);
    int n;
    n = 0;
    while (detail !== d && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n == 3000) begin
      chk(detail, d);
      results();
    end
  endtask

  always @(posedge clk) begin
    if (irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, hsel, hwrite, tj, drain, dis, htrans, haddr, hwdata} = '0;
    vin = 1'b1;
    {error_cnt, total_checks, irq_cnt} = '0;
    die_temp = 8'h00;
    band = BAND_NORMAL;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    ahb(0, OFS_CFG0, 0); chk(rd, 32'h5);
    ahb(0, OFS_CFG1, 0); chk(rd, 32'h2);
    ahb(0, 32'h20, 0); chk(rd, 32'h0);
    ahb(1, OFS_CFG2, 32'h403c3264);
    wait_det(DTL_CV); chk(ok, 1'b1);
    ahb(0, OFS_STATUS, 0); chk(rd & 32'hf73f, 32'h2212);
    wait_det(DTL_TOPOFF); chk(ok, 1'b1);
    base = irq_cnt;
    die_temp <= 8'h69;
    repeat (4) @(posedge clk);
    chk(fb, 1'b1); chk(cur_pct, 7'h4b); chk(irq_cnt, base + 1);
    ahb(0, OFS_STATUS, 0); chk(rd[5:4], 2'h3);
    die_temp <= 8'h00;
    repeat (4) @(posedge clk);
    chk(fb, 1'b0); chk(irq_cnt, base + 2); chk(ok, 1'b1);
    for (int i = 0; i < 5; i++) begin
      band <= bt[i];
      repeat (4) @(posedge clk);
      chk(chg_en, ben[i]);
      if (ben[i]) begin
        chk(cur_pct, bpc[i]); chk(cv_tgt, bcv[i]); chk(cv_drop, bdr[i]);
      end
    end
    ahb(1, OFS_CFG1, 32'h0);
    band <= BAND_COLD;
    repeat (4) @(posedge clk);
    chk(chg_en, 1'b1);
    ahb(0, OFS_STATUS, 0); chk(rd[10:8], BAND_NORMAL);
    ahb(1, OFS_CFG1, 32'h2);
    band <= BAND_NORMAL;
    drain <= 1'b1;
    wait_det(DTL_CC);
    drain <= 1'b0;
    wait_det(DTL_TOPOFF);
    ahb(1, OFS_WDCLR, 32'h1);
    ahb(1, OFS_CFG1, 32'h3);
    repeat (50) @(posedge clk);
    ahb(1, OFS_WDCLR, 32'h1);
    repeat (50) @(posedge clk);
    chk(detail, DTL_TOPOFF);
    base = irq_cnt;
    wait_det(DTL_WDOG);
    repeat (2) @(posedge clk);
    chk(chg_en, 1'b0); chk(ok, 1'b0); chk(irq_cnt, base + 1);
    ahb(1, OFS_WDCLR, 32'h1);
    ahb(1, OFS_CFG1, 32'h3e);
    wait_det(DTL_TOPOFF);
    base = irq_cnt;
    tj <= 1'b1;
    wait_det(DTL_DIE_SHUTDOWN_TEMPERATURE);
    repeat (2) @(posedge clk);
    chk(chg_en, 1'b0); chk(ok, 1'b0); chk(irq_cnt, base + 1);
    ahb(0, OFS_CFG1, 0); chk(rd, 32'h2);
    ahb(0, OFS_CFG2, 0); chk(rd, CFG2_RESET);
    ahb(0, OFS_CFG0, 0); chk(rd, 32'h5);
    // Second reset in a cold band: the cell cannot leave prequal
    tj <= 1'b0;
    band <= BAND_COLD;
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    wait_det(DTL_PREQUAL);
    repeat (2) @(posedge clk);
    base = irq_cnt;
    wait_det(DTL_TFAULT);
    repeat (2) @(posedge clk);
    chk(irq_cnt, base + 1); chk(ok, 1'b0);
    ahb(1, OFS_CFG0, 32'h0);
    ahb(1, OFS_CFG0, 32'h5);
    wait_det(DTL_PREQUAL);
    wait_det(DTL_TFAULT);
    band <= BAND_NORMAL;
    repeat (4) @(posedge clk);
    chk(chg_en, 1'b0); chk(softstart, 1'b0); chk(detail, DTL_TFAULT);
    dis <= 1'b1;
    @(posedge clk);
    dis <= 1'b0;
    wait_det(DTL_CC);
    chk(softstart, 1'b1);
    vin <= 1'b0;
    wait_det(DTL_IDLE);
    chk(chg_en, 1'b0);
    results();
  end
endmodule
